// File: acd_sink.sv
// Serial input end: clock sensing, ratio and rate detect, data capture.
// Assumes link pins are asynchronous; all sampled by core_clk.
`timescale 1ns/1ns
`default_nettype none
module acd_sink #(
  parameter int unsigned SYS_ABSENT = acd_pkg::SYS_ABSENT_FRAMES,
  parameter int unsigned BIT_BAD = acd_pkg::BIT_BAD_FRAMES
) (
  input wire logic core_clk,
  input wire logic resetn,
  acd_if.sink link,
  output logic [31:0] left_out,
  output logic [31:0] right_out,
  output logic sample_valid,
  output logic pll_enable,
  output logic locked,
  output logic force_zero,
  output logic [3:0] ratio_code,
  output logic [3:0] rate_code,
  output logic [1:0] filter_clk_sel,
  output logic [1:0] modulator_clk_sel,
  output logic [1:0] pump_clk_sel
);
  // ==========================================
  // Synchronisers
  logic [1:0] s_bck;
  logic [1:0] s_ws;
  logic [1:0] s_din;
  logic [1:0] s_sck;
  logic [1:0] s_fmt;
  logic bck_q;
  logic ws_q;
  logic sck_q;
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      s_bck <= 2'h0;
      s_ws <= 2'h0;
      s_din <= 2'h0;
      s_sck <= 2'h0;
      s_fmt <= 2'h0;
      bck_q <= 1'b0;
      ws_q <= 1'b0;
      sck_q <= 1'b0;
    end else begin
      s_bck <= {s_bck[0], link.bit_clock_in};
      s_ws <= {s_ws[0], link.word_select_clock};
      s_din <= {s_din[0], link.serial_data};
      s_sck <= {s_sck[0], link.sys_clk_pin};
      s_fmt <= {s_fmt[0], link.framing_select};
      bck_q <= s_bck[1];
      ws_q <= s_ws[1];
      sck_q <= s_sck[1];
    end
  end
  wire bck_rise = s_bck[1] & ~bck_q;
  wire ws_edge = s_ws[1] ^ ws_q;
  wire sck_rise = s_sck[1] & ~sck_q;
  wire lj = (s_fmt[1] == acd_pkg::FRAMING_LJ);
  wire frame_start = ws_edge && (lj ? s_ws[1] : ~s_ws[1]);
  // ==========================================
  // Ratio classification
  function automatic logic [3:0] sys_class(input logic [12:0] n);
    sys_class = acd_pkg::ACD_R_NONE;
    case (n)
      13'd64: sys_class = acd_pkg::ACD_R_64;
      13'd128: sys_class = acd_pkg::ACD_R_128;
      13'd192: sys_class = acd_pkg::ACD_R_192;
      13'd256: sys_class = acd_pkg::ACD_R_256;
      13'd384: sys_class = acd_pkg::ACD_R_384;
      13'd512: sys_class = acd_pkg::ACD_R_512;
      13'd768: sys_class = acd_pkg::ACD_R_768;
      13'd1024: sys_class = acd_pkg::ACD_R_1024;
      13'd1152: sys_class = acd_pkg::ACD_R_1152;
      13'd1536: sys_class = acd_pkg::ACD_R_1536;
      13'd2048: sys_class = acd_pkg::ACD_R_2048;
      13'd3072: sys_class = acd_pkg::ACD_R_3072;
      default: sys_class = acd_pkg::ACD_R_NONE;
    endcase
  endfunction
  // Rate by core cycles per frame, within 4 percent; 48k, 96k and 192k bands reach down to meet the 44.1k family bands
  function automatic logic [3:0] rate_class(input logic [15:0] c);
    logic [31:0] hz;
    hz = (c == 16'h0) ? 32'h0 : (acd_pkg::CORE_CLK_HZ / {16'h0, c});
    rate_class = acd_pkg::ACD_FS_NONE;
    if (hz >= 32'd7680 && hz <= 32'd8320) rate_class = acd_pkg::ACD_FS_8K;
    else if (hz >= 32'd15360 && hz <= 32'd16640) rate_class = acd_pkg::ACD_FS_16K;
    else if (hz >= 32'd30720 && hz <= 32'd33280) rate_class = acd_pkg::ACD_FS_32K;
    else if (hz >= 32'd42336 && hz <= 32'd45864) rate_class = acd_pkg::ACD_FS_44K1;
    else if (hz > 32'd45864 && hz <= 32'd49920) rate_class = acd_pkg::ACD_FS_48K;
    else if (hz >= 32'd84672 && hz <= 32'd91728) rate_class = acd_pkg::ACD_FS_88K2;
    else if (hz > 32'd91728 && hz <= 32'd99840) rate_class = acd_pkg::ACD_FS_96K;
    else if (hz >= 32'd169344 && hz <= 32'd183456) rate_class = acd_pkg::ACD_FS_176K4;
    else if (hz > 32'd183456 && hz <= 32'd199680) rate_class = acd_pkg::ACD_FS_192K;
    else if (hz >= 32'd368640 && hz <= 32'd399360) rate_class = acd_pkg::ACD_FS_384K;
    else rate_class = acd_pkg::ACD_FS_NONE;
  endfunction
  // ==========================================
  // Per-frame counters
  logic [12:0] sck_cnt;
  logic [12:0] sck_last;
  logic [6:0] bck_cnt;
  logic [15:0] core_cnt;
  logic [4:0] no_sck_frames;
  logic [2:0] bad_bck_frames;
  logic drift;
  logic have_ref;
  wire bck_ok = (bck_cnt == 7'd64) || (bck_cnt == 7'd48) || (bck_cnt == 7'd32);
  wire [12:0] sd = (sck_cnt > sck_last) ? (sck_cnt - sck_last) : (sck_last - sck_cnt);
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      sck_cnt <= 13'h0;
      sck_last <= 13'h0;
      bck_cnt <= 7'h0;
      core_cnt <= 16'h0;
      have_ref <= 1'b0;
      drift <= 1'b0;
    end else begin
      drift <= 1'b0;
      if (frame_start) begin
        // A rise in the boundary cycle belongs to the new frame
        sck_cnt <= sck_rise ? 13'h1 : 13'h0;
        bck_cnt <= bck_rise ? 7'h1 : 7'h0;
        core_cnt <= 16'h0;
        sck_last <= sck_cnt;
        have_ref <= (sck_cnt != 13'h0);
        // Full frame drift beyond five cycles triggers a restart
        drift <= have_ref && (sck_cnt != 13'h0) && (sd > 13'(acd_pkg::SYS_DRIFT_TOL));
      end else begin
        if (sck_rise && sck_cnt != 13'h1fff) sck_cnt <= sck_cnt + 13'h1;
        if (bck_rise && bck_cnt != 7'h7f) bck_cnt <= bck_cnt + 7'h1;
        if (core_cnt != 16'hffff) core_cnt <= core_cnt + 16'h1;
      end
    end
  end
  // ==========================================
  // Clock source and health
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      no_sck_frames <= 5'h0;
      bad_bck_frames <= 3'h0;
      pll_enable <= 1'b0;
    end else if (frame_start) begin
      if (sck_cnt != 13'h0) begin
        no_sck_frames <= 5'h0;
        pll_enable <= 1'b0;
      end else if (bck_ok) begin
        if (no_sck_frames == 5'(SYS_ABSENT - 1)) pll_enable <= 1'b1;
        else no_sck_frames <= no_sck_frames + 5'h1;
      end else begin
        no_sck_frames <= 5'h0;
      end
      if (bck_ok) bad_bck_frames <= 3'h0;
      else if (bad_bck_frames != 3'(BIT_BAD)) bad_bck_frames <= bad_bck_frames + 3'h1;
    end
  end
  wire bck_fail = frame_start && !bck_ok && (bad_bck_frames == 3'(BIT_BAD));
  // ==========================================
  // Lock, reinit and clock configuration
  logic [3:0] next_ratio;
  logic [3:0] next_rate;
  always_comb begin
    next_ratio = pll_enable ? acd_pkg::ACD_R_NONE : sys_class(sck_cnt);
    next_rate = rate_class(core_cnt);
  end
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      locked <= 1'b0;
      force_zero <= 1'b1;
      ratio_code <= 4'h0;
      rate_code <= 4'h0;
      filter_clk_sel <= 2'h0;
      modulator_clk_sel <= 2'h0;
      pump_clk_sel <= 2'h0;
    end else if (drift || bck_fail) begin
      locked <= 1'b0;
      force_zero <= 1'b1;
    end else if (frame_start) begin
      ratio_code <= next_ratio;
      rate_code <= next_rate;
      // Lock needs a good bit clock, a known rate, and either the PLL path or a known ratio
      locked <= bck_ok && next_rate != acd_pkg::ACD_FS_NONE &&
        (pll_enable || next_ratio != acd_pkg::ACD_R_NONE);
      force_zero <= !(bck_ok && next_rate != acd_pkg::ACD_FS_NONE);
      // Coarse band per rate group
      filter_clk_sel <= (next_rate >= acd_pkg::ACD_FS_176K4) ? 2'h3 :
        (next_rate >= acd_pkg::ACD_FS_88K2) ? 2'h2 : (next_rate != 4'h0) ? 2'h1 : 2'h0;
      modulator_clk_sel <= (next_rate >= acd_pkg::ACD_FS_88K2) ? 2'h2 : 2'h1;
      pump_clk_sel <= pll_enable ? 2'h2 : 2'h1;
    end
  end
  // ==========================================
  // Data capture; MSB first per half
  logic [31:0] shreg;
  logic [31:0] left_hold;
  logic [6:0] half_bits;
  logic skip;
  function automatic logic [31:0] align(input logic [31:0] w, input logic [6:0] n);
    align = w << (7'd32 - n);
  endfunction
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      shreg <= 32'h0;
      left_hold <= 32'h0;
      left_out <= 32'h0;
      right_out <= 32'h0;
      sample_valid <= 1'b0;
      half_bits <= 7'h0;
      skip <= 1'b0;
    end else begin
      sample_valid <= 1'b0;
      if (ws_edge && lj) begin
        // Word is left aligned; short words pad low bits
        if (~s_ws[1]) left_hold <= align(shreg, half_bits);
        else begin
          left_out <= force_zero ? 32'h0 : left_hold;
          right_out <= force_zero ? 32'h0 : align(shreg, half_bits);
          sample_valid <= locked;
        end
        shreg <= 32'h0;
        half_bits <= 7'h0;
      end else if (ws_edge) begin
        // Standard framing: the last bit of a word follows the word edge
        skip <= 1'b1;
      end else if (bck_rise) begin
        if (skip) begin
          skip <= 1'b0;
          if (s_ws[1]) left_hold <= align({shreg[30:0], s_din[1]}, half_bits + 7'h1);
          else begin
            left_out <= force_zero ? 32'h0 : left_hold;
            right_out <= force_zero ? 32'h0 : align({shreg[30:0], s_din[1]}, half_bits + 7'h1);
            sample_valid <= locked;
          end
          shreg <= 32'h0;
          half_bits <= 7'h0;
        end else if (half_bits != 7'd32) begin
          shreg <= {shreg[30:0], s_din[1]};
          half_bits <= half_bits + 7'h1;
        end
      end
      // Outputs sit at zero while resynchronising, even with no bit clock
      if (force_zero) begin
        left_out <= 32'h0;
        right_out <= 32'h0;
      end
    end
  end
endmodule
`default_nettype wire

// File: acd_pkg.sv
// Package for the audio clock detect and serial input block.
// Assumes a single core clock of 10 MHz shared by both ends.
package acd_pkg;
  // ==========================================
  // Timing
  localparam int unsigned CORE_CLK_HZ = 10000000;
  localparam int unsigned BIT_DIV_DEFAULT = 4;
  // ==========================================
  // Detection figures
  localparam int unsigned SYS_ABSENT_FRAMES = 16;
  localparam int unsigned BIT_BAD_FRAMES = 4;
  localparam int unsigned SYS_DRIFT_TOL = 5;
  localparam int unsigned TOL_PERCENT = 4;
  localparam int unsigned MAX_SYS_RATIO = 3072;
  // ==========================================
  // Framing
  localparam logic FRAMING_STD = 1'b0;
  localparam logic FRAMING_LJ = 1'b1;
  // ==========================================
  // Clock ratio codes
  typedef enum logic [3:0] {
    ACD_R_NONE, ACD_R_64, ACD_R_128, ACD_R_192, ACD_R_256, ACD_R_384, ACD_R_512,
    ACD_R_768, ACD_R_1024, ACD_R_1152, ACD_R_1536, ACD_R_2048, ACD_R_3072
  } acd_ratio_e;
  // Sample rate codes
  typedef enum logic [3:0] {
    ACD_FS_NONE, ACD_FS_8K, ACD_FS_16K, ACD_FS_32K, ACD_FS_44K1, ACD_FS_48K,
    ACD_FS_88K2, ACD_FS_96K, ACD_FS_176K4, ACD_FS_192K, ACD_FS_384K
  } acd_rate_e;
endpackage

// File: acd_if.sv
// Interface joining the audio source and the serial input.
// Assumes both ends share the core clock; link pins are plain wires.
`timescale 1ns/1ns
`default_nettype none
interface acd_if;
  logic sys_clk_pin;
  logic bit_clock_in;
  logic word_select_clock;
  logic serial_data;
  logic framing_select;
  modport source (output sys_clk_pin, output bit_clock_in, output word_select_clock,
    output serial_data, output framing_select);
  modport sink (input sys_clk_pin, input bit_clock_in, input word_select_clock,
    input serial_data, input framing_select);
endinterface
`default_nettype wire

// File: acd_source.sv
// Audio source end: makes bit and word clocks by dividing core clock.
// Assumes user presents a stereo pair when asked via sample_ready.
`timescale 1ns/1ns
`default_nettype none
module acd_source #(
  parameter int unsigned BIT_DIV = acd_pkg::BIT_DIV_DEFAULT,
  parameter int unsigned WORD_BITS = 32
) (
  input wire logic core_clk,
  input wire logic resetn,
  acd_if.source link,
  input wire logic [1:0] bits_per_half_sel,
  input wire logic lj_mode,
  input wire logic sys_clk_en,
  input wire logic [31:0] left_sample,
  input wire logic [31:0] right_sample,
  output logic sample_ready
);
  // ==========================================
  // Clock divider
  logic [7:0] div_cnt;
  logic bclk;
  logic sclk;
  logic [5:0] bit_idx;
  logic ws;
  logic [63:0] shreg;
  logic [31:0] right_hold;
  logic [5:0] half_len;
  always_comb begin
    case (bits_per_half_sel)
      2'h0: half_len = 6'h10;
      2'h1: half_len = 6'h18;
      default: half_len = 6'h20;
    endcase
  end
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      div_cnt <= 8'h00;
      bclk <= 1'b0;
      sclk <= 1'b0;
    end else begin
      // System clock at twice the bit clock, so the ratio follows the framing
      sclk <= (div_cnt == 8'((BIT_DIV / 2) - 1));
      if (div_cnt == 8'((BIT_DIV / 2) - 1)) begin
        div_cnt <= 8'h00;
        bclk <= ~bclk;
      end else begin
        div_cnt <= div_cnt + 8'h01;
      end
    end
  end
  wire fall = (div_cnt == 8'((BIT_DIV / 2) - 1)) && bclk;
  // ==========================================
  // Framing, data changes on falling edge
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      bit_idx <= 6'h00;
      ws <= 1'b0;
      shreg <= 64'h0;
      right_hold <= 32'h0;
      sample_ready <= 1'b0;
    end else begin
      sample_ready <= 1'b0;
      if (fall) begin
        if (bit_idx == half_len - 6'h01) begin
          bit_idx <= 6'h00;
          ws <= ~ws;
          if (ws) begin
            shreg <= {left_sample, right_sample};
            right_hold <= right_sample;
            sample_ready <= 1'b1;
          end else begin
            // Right word restarts at its MSB whatever the word length
            shreg <= {right_hold, 32'h0};
          end
        end else begin
          bit_idx <= bit_idx + 6'h01;
          shreg <= {shreg[62:0], 1'b0};
        end
      end
    end
  end
  assign link.bit_clock_in = bclk;
  // Standard framing delays data by one bit after the word edge
  logic data_d;
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) data_d <= 1'b0;
    else if (fall) data_d <= shreg[63];
  end
  // Left word goes out while ws is low: low in standard, high in left justified
  assign link.word_select_clock = lj_mode ? ~ws : ws;
  assign link.serial_data = lj_mode ? shreg[63] : data_d;
  assign link.framing_select = lj_mode;
  assign link.sys_clk_pin = sys_clk_en & sclk;
endmodule
`default_nettype wire

// File: acd_props.sv
// Checker for the serial audio link between source and sink ends.
// Assumes one core clock samples every link pin.
`timescale 1ns/1ns
`default_nettype none
module acd_props (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic sys_clk_pin,
  input wire logic bit_clock_in,
  input wire logic word_select_clock,
  input wire logic serial_data,
  input wire logic framing_select
);
  logic [7:0] rises;
  logic seen;
  logic wq;
  logic bq;
  // ==========================================
  // Bit clock rises per half frame
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      wq <= 1'b0;
      bq <= 1'b0;
      rises <= 8'h00;
      seen <= 1'b0;
    end else begin
      wq <= word_select_clock;
      bq <= bit_clock_in;
      if (word_select_clock != wq) begin
        rises <= 8'h00;
        seen <= 1'b1;
      end else if (bit_clock_in && !bq) begin
        rises <= rises + 8'h01;
      end
    end
  end
  // ==========================================
  // Link timing
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);
  a_data_stable_rise: assert property ($rose(bit_clock_in) |-> $stable(serial_data))
    else $error("data moved at bit clock rise");
  a_word_on_low: assert property ($changed(word_select_clock) |-> !bit_clock_in)
    else $error("word edge while bit clock high");
  a_bclk_high_width: assert property ($rose(bit_clock_in) |=> bit_clock_in[*4] ##1 !bit_clock_in)
    else $error("bit clock high width");
  a_bclk_low_width: assert property ($fell(bit_clock_in) |=> !bit_clock_in[*4] ##1 bit_clock_in)
    else $error("bit clock low width");
  a_sys_clk_bound: assert property (sys_clk_pin |=> !sys_clk_pin)
    else $error("system clock above half core rate");
  a_word_hold_min: assert property ($changed(word_select_clock) |=> $stable(word_select_clock)[*8])
    else $error("word half too short");
  a_word_next_bound: assert property ($changed(word_select_clock) |-> ##[1:330] $changed(word_select_clock))
    else $error("word half too long");
  a_bits_per_half: assert property (seen && $changed(word_select_clock) |-> rises inside {8'h10, 8'h18, 8'h20})
    else $error("bit clocks per half not 16, 24 or 32");
  c_lj: cover property ($changed(word_select_clock) && framing_select);
  c_std: cover property ($changed(word_select_clock) && !framing_select);
  c_sys: cover property ($rose(sys_clk_pin));
endmodule
`default_nettype wire

// File: tb.sv
// Bench: source and sink face each other; a second sink gets faulty frames.
// Assumes a 10 MHz core clock shared by every end.
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic [1:0] sel = 2'h2;
  logic lj = 1'b0;
  logic sys_en = 1'b1;
  logic chk = 1'b0;
  logic synced = 1'b0;
  logic [31:0] lsmp = 32'h0;
  logic [31:0] rsmp = 32'h0;
  logic rdy, vld, pll, lck, fz, lck2, fz2;
  logic [31:0] lo, ro, lo2, ro2;
  logic [3:0] ratio, rate;
  logic [63:0] q[$];
  int miscompares = 0;
  int n_tests = 0;
  int good = 0;
  acd_if link();
  acd_if link2();
  always #50 core_clk = ~core_clk;
  acd_source #(.BIT_DIV(10)) u_acd_source (.core_clk(core_clk),
    .resetn(resetn), .link(link.source), .bits_per_half_sel(sel), .lj_mode(lj),
    .sys_clk_en(sys_en), .left_sample(lsmp), .right_sample(rsmp), .sample_ready(rdy));
  acd_sink #(.SYS_ABSENT(2), .BIT_BAD(2)) u_acd_sink (.core_clk(core_clk), .resetn(resetn),
    .link(link.sink), .left_out(lo), .right_out(ro), .sample_valid(vld), .pll_enable(pll),
    .locked(lck), .force_zero(fz), .ratio_code(ratio), .rate_code(rate),
    .filter_clk_sel(), .modulator_clk_sel(), .pump_clk_sel());
  acd_sink #(.SYS_ABSENT(2), .BIT_BAD(2)) u_acd_sink_fault (.core_clk(core_clk),
    .resetn(resetn), .link(link2.sink), .left_out(lo2), .right_out(ro2), .sample_valid(),
    .pll_enable(), .locked(lck2), .force_zero(fz2), .ratio_code(), .rate_code(),
    .filter_clk_sel(), .modulator_clk_sel(), .pump_clk_sel());
  acd_props u_acd_props (.core_clk(core_clk), .resetn(resetn),
    .sys_clk_pin(link.sys_clk_pin), .bit_clock_in(link.bit_clock_in),
    .word_select_clock(link.word_select_clock), .serial_data(link.serial_data),
    .framing_select(link.framing_select));
  // ==========================================
  // Expectations and compares
  function automatic logic [31:0] pick();
    case (2'($urandom))
      2'h0: return 32'h80000000;
      2'h1: return 32'h7fffffff;
      default: return $urandom;
    endcase
  endfunction
  function automatic logic [63:0] trunc(logic [63:0] p);
    logic [31:0] m;
    m = (sel == 2'h0) ? 32'hffff0000 : (sel == 2'h1) ? 32'hffffff00 : 32'hffffffff;
    return p & {m, m};
  endfunction
  task automatic cmp_data(logic [63:0] got, logic [63:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %0t data %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cmp_bit(logic got, logic exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %0t flag %b exp %b", $time, got, exp);
    end
  endtask
  task automatic cmp_code(logic [3:0] got, logic [3:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %0t code %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    if (miscompares == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // First pair after reset may be partial, so alignment is searched again whenever force_zero was set
  task automatic check_pair();
    int i;
    i = 0;
    if (!synced) begin
      while (i < q.size() && trunc(q[i]) !== {lo, ro}) i++;
      if (i < q.size()) synced = 1'b1;
    end
    if (synced) begin
      q = q[i:$];
      cmp_data({lo, ro}, trunc(q.pop_front()));
      good++;
    end
  endtask
  always @(posedge core_clk) begin
    if (rdy === 1'b1) begin
      q.push_back({lsmp, rsmp});
      lsmp <= pick();
      rsmp <= pick();
    end
    if (fz === 1'b1) synced = 1'b0;
    if (vld === 1'b1 && chk) check_pair();
  end
  // ==========================================
  // Drivers
  task automatic do_reset(logic [1:0] s, logic l, logic e);
    resetn <= 1'b0;
    chk <= 1'b0;
    sel <= s;
    lj <= l;
    sys_en <= e;
    repeat (4) @(posedge core_clk);
    cmp_bit(fz, 1'b1);
    cmp_bit(lck, 1'b0);
    cmp_code(ratio, 4'h0);
    q.delete();
    synced = 1'b0;
    good = 0;
    resetn <= 1'b1;
    chk <= 1'b1;
  endtask
  task automatic frames(int n);
    logic w;
    int t;
    repeat (2 * n) begin
      w = link.word_select_clock;
      t = 0;
      while (link.word_select_clock === w && t < 400) begin
        @(posedge core_clk);
        t++;
      end
      if (t >= 400) begin
        $display("MISMATCH %0t word clock stalled", $time);
        miscompares++;
        tally_and_finish();
      end
    end
  endtask
  // Frame of 320 cycles, 32 bit clocks; bad holds bit clock low, stall drops 6 system clocks
  task automatic f2(logic bad, logic stall, int from, int to);
    for (int c = from; c < to; c++) begin
      @(posedge core_clk);
      link2.bit_clock_in <= ((c % 10) >= 5) && !bad;
      link2.word_select_clock <= (c >= 160);
      link2.sys_clk_pin <= ((c % 5) == 0) && !(stall && c >= 100 && c < 130);
      if ((c % 10) == 0) link2.serial_data <= 1'($urandom);
    end
  endtask
  // ==========================================
  // Scenarios
  initial begin
    link2.sys_clk_pin = 1'b0;
    link2.bit_clock_in = 1'b0;
    link2.word_select_clock = 1'b0;
    link2.serial_data = 1'b0;
    link2.framing_select = 1'b0;
    void'($urandom(32'h196371bf));
    // A 1 us bit clock gives 16 kHz at 64 and 32 kHz at 32 bit clocks a frame
    do_reset(2'h2, 1'b0, 1'b1);
    frames(8);
    cmp_code(ratio, acd_pkg::ACD_R_128);
    cmp_code(rate, acd_pkg::ACD_FS_16K);
    cmp_bit(pll, 1'b0);
    cmp_bit(lck, 1'b1);
    cmp_bit(good > 2, 1'b1);
    do_reset(2'h0, 1'b1, 1'b1);
    frames(8);
    cmp_code(ratio, acd_pkg::ACD_R_64);
    cmp_code(rate, acd_pkg::ACD_FS_32K);
    cmp_bit(good > 2, 1'b1);
    do_reset(2'h2, 1'b0, 1'b0);
    frames(1);
    cmp_bit(pll, 1'b0);
    frames(7);
    cmp_bit(pll, 1'b1);
    cmp_bit(good > 2, 1'b1);
    chk <= 1'b0;
    sys_en <= 1'b1;
    frames(2);
    cmp_bit(pll, 1'b0);
    do_reset(2'h2, 1'b0, 1'b1);
    repeat (6) f2(1'b0, 1'b0, 0, 320);
    cmp_bit(lck2, 1'b1);
    repeat (4) f2(1'b1, 1'b0, 0, 320);
    cmp_bit(fz2, 1'b1);
    cmp_bit(lck2, 1'b0);
    cmp_data({lo2, ro2}, 64'h0);
    repeat (3) f2(1'b0, 1'b0, 0, 320);
    cmp_bit(fz2, 1'b0);
    f2(1'b0, 1'b1, 0, 320);
    f2(1'b0, 1'b0, 0, 40);
    cmp_bit(fz2, 1'b1);
    f2(1'b0, 1'b0, 40, 320);
    repeat (3) f2(1'b0, 1'b0, 0, 320);
    cmp_bit(fz2, 1'b0);
    tally_and_finish();
  end
endmodule
`default_nettype wire
